// *** hdl/trig_sync_consts.vh ***
// Constants for the PWM synchronous sampling-trigger controller.
`ifndef TRIG_SYNC_CONSTS_VH
`define TRIG_SYNC_CONSTS_VH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_CMP0 8'h00
`define ADDR_CMP1 8'h04
`define ADDR_CMP2 8'h08
`define ADDR_CMP3 8'h0C
`define ADDR_CTRL 8'h10
`define ADDR_SYNC 8'h14
`define ADDR_OMODE 8'h18
`define ADDR_RSEL 8'h1C
// ----------------------------------------------------------------------------
// Field layouts and codes
// ----------------------------------------------------------------------------
`define CTRL_W 16
`define CH_FIELD_W 4
`define MODE_W 3
`define ASYNC_BIT 3
`define CMP_STRIDE 8'h04
`define CMP_SINGLE 16'h0001
`define MODE_OFF 3'h0
`define MODE_DOWN 3'h1
`define MODE_UP 3'h2
`define MODE_BOTH 3'h3
`define MODE_PEAK 3'h4
`define MODE_BOT 3'h5
`define MODE_PB 3'h6
`define TS_CHAN 2'h0
`define TS_BOT 2'h1
`define TS_PEAK 2'h2
`define TS_PB 2'h3
`define OMODE_PASS_BIT 0
`define OMODE_VAR_BIT 1
`define RSEL_LAST 3'h5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** hdl/trig_channel.v ***
// One compare channel: double-buffered compare value and match-mode trigger logic.
`timescale 1ns/10ps
`include "trig_sync_consts.vh"
module trig_channel #(
  parameter CW = 16
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [2:0] match_mode_i,
  input wire async_update_i,
  input wire [1:0] update_timing_i,
  input wire pwm_enable_i,
  input wire sawtooth_i,
  input wire carrier_peak_i,
  input wire carrier_bottom_i,
  input wire count_down_i,
  input wire [CW-1:0] counter_i,
  input wire wr_i,
  input wire [CW-1:0] wdata_i,
  output wire [CW-1:0] first_stage_o,
  output wire trigger_o
);
  reg [CW-1:0] stage1_ff;
  reg [CW-1:0] stage2_ff;
  reg pend_ff;
  reg [CW-1:0] last_cnt_ff;
  reg seen_ff;
  reg edge_pb;
  reg load_now;
  reg fire;
  wire match;
  wire up_dir;
  wire carrier_edge;
  wire single_cmp;
  localparam [CW-1:0] SINGLE_CMP = `CMP_SINGLE;

  // ----------------------------------------------------------------------------
  // Transfer timing
  // ----------------------------------------------------------------------------
  // With sawtooth the either-edge update collapses to the peak only.
  always @*
  begin
    edge_pb = sawtooth_i ? carrier_peak_i : (carrier_peak_i | carrier_bottom_i);
    load_now = 1'b0;
    if (!pwm_enable_i || async_update_i)
      load_now = 1'b1;
    else
      case (update_timing_i)
        `TS_BOT: load_now = carrier_bottom_i;
        `TS_PEAK: load_now = carrier_peak_i;
        `TS_PB: load_now = edge_pb;
        default:
          case (match_mode_i)
            `MODE_DOWN: load_now = carrier_peak_i;
            `MODE_UP: load_now = carrier_bottom_i;
            `MODE_BOTH: load_now = edge_pb;
            default: load_now = 1'b1;
          endcase
      endcase
  end

  // Writes land in the first stage; a pending flag remembers a sync transfer.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stage1_ff <= {CW{1'b0}};
      stage2_ff <= {CW{1'b0}};
      pend_ff <= 1'b0;
    end
    else
    begin
      if (wr_i)
        stage1_ff <= wdata_i;
      if (wr_i && load_now)
        stage2_ff <= wdata_i;
      else if (pend_ff && load_now)
        stage2_ff <= stage1_ff;
      if (wr_i)
        pend_ff <= !load_now;
      else if (load_now)
        pend_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Trigger generation
  // ----------------------------------------------------------------------------
  // A counter parked on the compare value for several clocks fires only once.
  assign match = (counter_i == stage2_ff) && !(seen_ff && last_cnt_ff == counter_i);
  // Sawtooth counts up only, so any match counts as up-count.
  assign up_dir = sawtooth_i || !count_down_i;
  assign carrier_edge = carrier_peak_i | carrier_bottom_i;
  // A compare of one sits beside the bottom on both slopes of a triangle; count it once.
  assign single_cmp = !sawtooth_i && (stage2_ff == SINGLE_CMP);

  always @*
  begin
    case (match_mode_i)
      `MODE_DOWN: fire = match && (sawtooth_i || count_down_i);
      `MODE_UP: fire = match && up_dir;
      `MODE_BOTH: fire = match && !(single_cmp && count_down_i);
      `MODE_PEAK: fire = carrier_peak_i;
      `MODE_BOT: fire = sawtooth_i ? carrier_peak_i : carrier_bottom_i;
      `MODE_PB: fire = sawtooth_i ? carrier_peak_i : carrier_edge;
      default: fire = 1'b0;
    endcase
  end

  // Remember the previous count and whether it matched, so a dwell does not repeat the pulse.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      last_cnt_ff <= {CW{1'b0}};
      seen_ff <= 1'b0;
    end
    else
    begin
      last_cnt_ff <= counter_i;
      seen_ff <= (counter_i == stage2_ff);
    end
  end

  assign first_stage_o = stage1_ff;
  assign trigger_o = fire;
endmodule // trig_channel

// *** hdl/trig_sync_ctrl.v ***
// PWM synchronous sampling-trigger controller with an AXI4-Lite register slave.
`timescale 1ns/10ps
`include "trig_sync_consts.vh"
module trig_sync_ctrl #(
  parameter CW = 16
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [CW-1:0] pwm_counter_i,
  input wire count_down_i,
  input wire carrier_peak_i,
  input wire carrier_bottom_i,
  input wire pwm_enable_i,
  input wire sawtooth_i,
  input wire duty_update_i,
  input wire emergency_protection_i,
  output reg [5:0] trigger_line_o
);
  // ----------------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------------
  reg [`CTRL_W-1:0] ctrl_ff;
  reg [1:0] timing_ff;
  reg [1:0] omode_ff;
  reg [2:0] rsel_buf_ff;
  reg [2:0] rsel_act_ff;
  reg aw_ff;
  reg w_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [5:0] nxt_trig;
  reg [31:0] nxt_rdata;
  wire do_write;
  wire full_word;
  wire wr_ctrl;
  wire wr_sync;
  wire wr_omode;
  wire wr_rsel;
  wire var_mode;
  wire pass_in_protect;
  wire [CW-1:0] cmp_rd [0:3];
  wire [3:0] ch_trig;
  wire gate_open;

  // Address decode shared by read and write paths.
  // Offsets above the last register or off a word boundary are refused.
  function known_addr;
    input [7:0] a;
    begin
      known_addr = (a[1:0] == 2'h0) && (a <= `ADDR_RSEL);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------------
  // Address and data are captured independently, in either order.
  assign s_axi_awready_o = !aw_ff && !bvalid_ff;
  assign s_axi_wready_o = !w_ff && !bvalid_ff;
  // One response slot only: while it is full both channels stall, so no write is lost.
  assign do_write = aw_ff && w_ff && !bvalid_ff;
  // Compare halves written separately would be unsafe, so partial writes to them are dropped.
  assign full_word = (wstrb_ff[1:0] == 2'h3);

  // ----------------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------------
  // Narrow registers take only byte lane 0; other lanes are ignored, not refused.
  // The decode is shared so the register process stays a plain list of updates.
  assign wr_ctrl = do_write && (awaddr_ff == `ADDR_CTRL);
  assign wr_sync = do_write && (awaddr_ff == `ADDR_SYNC) && wstrb_ff[0];
  assign wr_omode = do_write && (awaddr_ff == `ADDR_OMODE) && wstrb_ff[0];
  assign wr_rsel = do_write && (awaddr_ff == `ADDR_RSEL) && wstrb_ff[0];

  // The response rises one clock after both halves are held and stands until bready.
  // Holding each half in its own flag lets the master offer them in either order.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= known_addr(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready_i)
        bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;

  // Control registers; narrow fields only take their low byte lane.
  // Reserved bits are not stored, so they always read back as zero.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_ff <= {`CTRL_W{1'b0}};
      timing_ff <= `TS_CHAN;
      omode_ff <= 2'h0;
      rsel_buf_ff <= 3'h0;
    end
    else
    begin
      if (wr_ctrl && wstrb_ff[0])
        ctrl_ff[7:0] <= wdata_ff[7:0];
      if (wr_ctrl && wstrb_ff[1])
        ctrl_ff[15:8] <= wdata_ff[15:8];
      if (wr_sync)
        timing_ff <= wdata_ff[1:0];
      if (wr_omode)
        omode_ff <= wdata_ff[1:0];
      if (wr_rsel)
        rsel_buf_ff <= wdata_ff[2:0];
    end
  end

  // Route selector second stage follows the duty-compare update strobe, or copies every clock while PWM is disabled.
  // Staging keeps a mid-period change from moving a trigger already under way.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rsel_act_ff <= 3'h0;
    else if (!pwm_enable_i)
      rsel_act_ff <= rsel_buf_ff;
    else if (duty_update_i)
      rsel_act_ff <= rsel_buf_ff;
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------------
  assign s_axi_arready_o = !rvalid_ff;

  // Read mux; unmapped or unaligned offsets read as zero and answer with an error.
  always @*
  begin
    case (s_axi_araddr_i)
      `ADDR_CMP0: nxt_rdata = {16'h0000, cmp_rd[0]};
      `ADDR_CMP1: nxt_rdata = {16'h0000, cmp_rd[1]};
      `ADDR_CMP2: nxt_rdata = {16'h0000, cmp_rd[2]};
      `ADDR_CMP3: nxt_rdata = {16'h0000, cmp_rd[3]};
      `ADDR_CTRL: nxt_rdata = {16'h0000, ctrl_ff};
      `ADDR_SYNC: nxt_rdata = {30'h0000_0000, timing_ff};
      `ADDR_OMODE: nxt_rdata = {30'h0000_0000, omode_ff};
      `ADDR_RSEL: nxt_rdata = {29'h0000_0000, rsel_buf_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // The answer is held in flip-flops so it stands unchanged until rready.
  // A new address is refused meanwhile, so one read at most is under way.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `RESP_OKAY;
    end
    else if (s_axi_arvalid_i && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= known_addr(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_ff <= nxt_rdata;
    end
    else if (rvalid_ff && s_axi_rready_i)
      rvalid_ff <= 1'b0;
  end
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // ----------------------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------------------
  // Each channel decodes its own compare offset; the offsets lie one word apart.
  // The timer events fan out to all four channels unchanged, so they stay aligned.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      localparam [31:0] CMP_OFS = `ADDR_CMP0 + `CMP_STRIDE * g;
      trig_channel #(.CW(CW)) trig_channel_inst (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .match_mode_i(ctrl_ff[g*`CH_FIELD_W +: `MODE_W]),
        .async_update_i(ctrl_ff[g*`CH_FIELD_W + `ASYNC_BIT]),
        .update_timing_i(timing_ff),
        .pwm_enable_i(pwm_enable_i),
        .sawtooth_i(sawtooth_i),
        .carrier_peak_i(carrier_peak_i),
        .carrier_bottom_i(carrier_bottom_i),
        .count_down_i(count_down_i),
        .counter_i(pwm_counter_i),
        .wr_i(do_write && full_word && awaddr_ff == CMP_OFS[7:0]),
        .wdata_i(wdata_ff[CW-1:0]),
        .first_stage_o(cmp_rd[g]),
        .trigger_o(ch_trig[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Output routing and protection gating
  // ----------------------------------------------------------------------------
  // Triggers are blocked while protection is active unless software lets them pass.
  assign var_mode = omode_ff[`OMODE_VAR_BIT];
  assign pass_in_protect = omode_ff[`OMODE_PASS_BIT];
  assign gate_open = !emergency_protection_i || pass_in_protect;

  // Fixed mode maps channel n to line n; variable mode steers channel 0 alone.
  // Gating acts after routing, so a blocked trigger is lost, not delayed.
  always @*
  begin
    nxt_trig = 6'h00;
    if (!var_mode)
      nxt_trig = {2'b00, ch_trig};
    else if (rsel_act_ff <= `RSEL_LAST)
      nxt_trig[rsel_act_ff] = ch_trig[0];
    if (!gate_open)
      nxt_trig = 6'h00;
  end

  // Registered outputs; each channel raises at most one clock per event.
  // Registering costs a clock of latency but keeps glitches off the lines.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      trigger_line_o <= 6'h00;
    else
      trigger_line_o <= nxt_trig;
  end
endmodule // trig_sync_ctrl

// *** verif/trig_sync_ctrl_assertions.sv ***
// Checker for the trigger controller register bus and trigger lines.
`timescale 1ns/10ps
`include "trig_sync_consts.vh"
module trig_sync_ctrl_assertions (
  input wire clk_i,
  input wire rst_b_i,
  input wire s_axi_awready_o,
  input wire s_axi_wready_o,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [5:0] trigger_line_o
);
  // ----------------
  // Properties
  // ----------------
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_trig_single: assert property (|trigger_line_o |=>
    (trigger_line_o & $past(trigger_line_o)) == 6'h00) else $error("trigger wider than a clock");
  chk_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  chk_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  chk_ar_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken while data pending");
  chk_aw_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  chk_read_lat: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  chk_write_lat: assert property ($rose(s_axi_bvalid_o) |->
    !$past(s_axi_awready_o) && !$past(s_axi_wready_o)) else $error("response before both halves");
  chk_bresp_code: assert property (s_axi_bvalid_o |->
    s_axi_bresp_o == `RESP_OKAY || s_axi_bresp_o == `RESP_SLVERR) else $error("bad response");
  chk_err_data: assert property (s_axi_rvalid_o && s_axi_rresp_o != `RESP_OKAY |->
    s_axi_rdata_o == 32'h00000000) else $error("refused read returned data");
endmodule // trig_sync_ctrl_assertions

// *** verif/adc_start_model.sv ***
// Model of the sampling start logic: counts start requests on each line.
`timescale 1ns/10ps
module adc_start_model (
  input wire clk_i,
  input wire rst_b_i,
  input wire clr_i,
  input wire [5:0] trigger_line_i,
  output logic [23:0] start_count_o
);
  // Four bits a line; the bench clears between checks so they never wrap.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i || clr_i)
      start_count_o <= 24'h000000;
    else
      for (int k = 0; k < 6; k++)
        start_count_o[4*k +: 4] <= start_count_o[4*k +: 4] + {3'h0, trigger_line_i[k]};
  end
endmodule // adc_start_model

// *** verif/tb_trig_sync_ctrl.sv ***
// Self-checking bench for the sampling-trigger controller.
`timescale 1ns/10ps
`include "trig_sync_consts.vh"
module tb_trig_sync_ctrl;
  // ----------------
  // Bench state
  // ----------------
  logic clk_i, rst_b_i, awv, wv, bry, arv, rry, dn, pk, bt, en, saw, du, emergency_protection, clr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] strb;
  logic [15:0] cnt;
  int miscompares, total_checks;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire [5:0] trigger_line_o;
  wire [23:0] starts;
  // Strobes stay full except where a partial compare write is tried on purpose.
  trig_sync_ctrl trig_sync_ctrl_inst (
    .clk_i,
    .rst_b_i,
    .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awv),
    .s_axi_awready_o,
    .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(strb),
    .s_axi_wvalid_i(wv),
    .s_axi_wready_o,
    .s_axi_bresp_o,
    .s_axi_bvalid_o,
    .s_axi_bready_i(bry),
    .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv),
    .s_axi_arready_o,
    .s_axi_rdata_o,
    .s_axi_rresp_o,
    .s_axi_rvalid_o,
    .s_axi_rready_i(rry),
    .pwm_counter_i(cnt),
    .count_down_i(dn),
    .carrier_peak_i(pk),
    .carrier_bottom_i(bt),
    .pwm_enable_i(en),
    .sawtooth_i(saw),
    .duty_update_i(du),
    .emergency_protection_i(emergency_protection),
    .trigger_line_o
  );
  adc_start_model adc_start_model_inst (
    .clk_i,
    .rst_b_i,
    .clr_i(clr),
    .trigger_line_i(trigger_line_o),
    .start_count_o(starts)
  );
  // System clock.
  always #25 clk_i = ~clk_i;
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 40)
    begin
      miscompares++;
      $display("mismatch at %0t: bus wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Ready is raised late on purpose so the slave must hold its answer.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      if (awv && s_axi_awready_o)
        awv <= 1'h0;
      if (wv && s_axi_wready_o)
        wv <= 1'h0;
      if (s_axi_bvalid_o && bry)
        break;
      if (s_axi_bvalid_o)
        bry <= 1'h1;
    end
    bry <= 1'h0;
    hang(n);
    chk(s_axi_bresp_o, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    araddr <= a;
    arv <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      if (arv && s_axi_arready_o)
        arv <= 1'h0;
      if (s_axi_rvalid_o && rry)
        break;
      if (s_axi_rvalid_o)
        rry <= 1'h1;
    end
    rry <= 1'h0;
    hang(n);
    chk(s_axi_rdata_o, ed);
    chk(s_axi_rresp_o, er);
  endtask
  task automatic step(input logic [15:0] c, input logic d, input logic p, input logic b);
    @(posedge clk_i);
    cnt <= c;
    dn <= d;
    pk <= p;
    bt <= b;
  endtask
  task automatic peak();
    step(16'h0008, 1'h0, 1'h1, 1'h0);
  endtask
  task automatic bottom();
    step(16'h0000, 1'h0, 1'h0, 1'h1);
  endtask
  task automatic down(input logic [15:0] c);
    step(c, 1'h1, 1'h0, 1'h0);
  endtask
  // Sixteen-clock carrier: triangle 0..8..1, or sawtooth 0..15.
  task automatic period(input logic s);
    for (int t = 0; t < 16; t++)
      step(s ? 16'(t) : 16'(t > 8 ? 16 - t : t), !s && t > 8, s ? t == 15 : t == 8, t == 0);
  endtask
  // Idle long enough for the last pulse to be counted, compare, then clear.
  task automatic expect_starts(input logic [23:0] e);
    repeat (3)
      step(16'h00F0, 1'h0, 1'h0, 1'h0);
    chk(starts, e);
    clr <= 1'h1;
    @(posedge clk_i);
    clr <= 1'h0;
  endtask
  task automatic s_regs();
    logic [15:0] m [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h3, 16'h3, 16'h7};
    for (int i = 0; i < 8; i++)
    begin
      axi_rd(8'(4 * i), 32'h0, `RESP_OKAY);
      axi_wr(8'(4 * i), 32'hFFFFFFFF, `RESP_OKAY);
      axi_rd(8'(4 * i), {16'h0, m[i]}, `RESP_OKAY);
      axi_wr(8'(4 * i), 32'h0, `RESP_OKAY);
    end
    axi_rd(8'h20, 32'h0, `RESP_SLVERR);
    axi_wr(8'h22, 32'h1, `RESP_SLVERR);
    strb <= 4'h1;
    axi_wr(`ADDR_CMP0, 32'h1234, `RESP_OKAY);
    strb <= 4'hF;
    axi_rd(`ADDR_CMP0, 32'h0, `RESP_OKAY);
  endtask
  task automatic s_modes();
    logic [15:0] c [2] = '{16'h8BA9, 16'hFEDC};
    en <= 1'h1;
    for (int i = 0; i < 4; i++)
      axi_wr(8'(4 * i), 32'h3, `RESP_OKAY);
    for (int i = 0; i < 2; i++)
    begin
      axi_wr(`ADDR_CTRL, {16'h0, c[i]}, `RESP_OKAY);
      period(1'h0);
      period(1'h0);
      expect_starts(24'h000422);
    end
  endtask
  task automatic s_saw();
    saw <= 1'h1;
    axi_wr(`ADDR_CTRL, 32'hD9, `RESP_OKAY);
    period(1'h1);
    period(1'h1);
    expect_starts(24'h000022);
    saw <= 1'h0;
    axi_wr(`ADDR_CMP0, 32'h1, `RESP_OKAY);
    axi_wr(`ADDR_CTRL, 32'hB, `RESP_OKAY);
    period(1'h0);
    period(1'h0);
    expect_starts(24'h2);
  endtask
  // Staged compare transfer, held back until the chosen carrier event.
  task automatic s_sync();
    axi_wr(`ADDR_CMP0, 32'h3, `RESP_OKAY);
    axi_wr(`ADDR_CTRL, 32'h1, `RESP_OKAY);
    axi_wr(`ADDR_CMP0, 32'h5, `RESP_OKAY);
    axi_rd(`ADDR_CMP0, 32'h5, `RESP_OKAY);
    down(16'h0003);
    expect_starts(24'h1);
    bottom();
    down(16'h0005);
    expect_starts(24'h0);
    peak();
    down(16'h0005);
    expect_starts(24'h1);
    axi_wr(`ADDR_SYNC, 32'h1, `RESP_OKAY);
    axi_wr(`ADDR_CMP0, 32'h3, `RESP_OKAY);
    peak();
    down(16'h0003);
    expect_starts(24'h0);
    bottom();
    down(16'h0003);
    expect_starts(24'h1);
    en <= 1'h0;
    axi_wr(`ADDR_CMP0, 32'h5, `RESP_OKAY);
    en <= 1'h1;
    down(16'h0005);
    expect_starts(24'h1);
    saw <= 1'h1;
    axi_wr(`ADDR_SYNC, 32'h3, `RESP_OKAY);
    axi_wr(`ADDR_CMP0, 32'h3, `RESP_OKAY);
    bottom();
    down(16'h0003);
    expect_starts(24'h0);
    peak();
    down(16'h0003);
    expect_starts(24'h1);
    saw <= 1'h0;
    axi_wr(`ADDR_SYNC, 32'h0, `RESP_OKAY);
  endtask
  task automatic s_route();
    axi_wr(`ADDR_CTRL, 32'hCC, `RESP_OKAY);
    axi_wr(`ADDR_OMODE, 32'h2, `RESP_OKAY);
    for (int k = 0; k < 8; k++)
    begin
      axi_wr(`ADDR_RSEL, 32'(k), `RESP_OKAY);
      du <= 1'h1;
      step(16'h00F0, 1'h0, 1'h0, 1'h0);
      du <= 1'h0;
      peak();
      expect_starts(k < 6 ? 24'h1 << (4 * k) : 24'h0);
    end
    axi_wr(`ADDR_RSEL, 32'h2, `RESP_OKAY);
    peak();
    expect_starts(24'h0);
    axi_wr(`ADDR_OMODE, 32'h0, `RESP_OKAY);
    peak();
    expect_starts(24'h11);
  endtask
  task automatic s_protect();
    emergency_protection <= 1'h1;
    peak();
    expect_starts(24'h0);
    axi_wr(`ADDR_OMODE, 32'h1, `RESP_OKAY);
    peak();
    expect_starts(24'h11);
    emergency_protection <= 1'h0;
  endtask
  // Main sequence after six clocks of reset.
  initial
  begin
    clk_i = 1'h0;
    rst_b_i = 1'h0;
    {awv, wv, bry, arv, rry, dn, pk, bt, en, saw, du, emergency_protection, clr} = 13'h0;
    {awaddr, araddr, wdata, cnt} = 64'h0;
    strb = 4'hF;
    miscompares = 0;
    total_checks = 0;
    repeat (6)
      @(posedge clk_i);
    rst_b_i <= 1'h1;
    s_regs();
    s_modes();
    s_saw();
    s_sync();
    s_route();
    s_protect();
    tally_and_finish();
  end
endmodule // tb_trig_sync_ctrl
bind trig_sync_ctrl trig_sync_ctrl_assertions trig_sync_ctrl_assertions_inst (.clk_i, .rst_b_i,
  .s_axi_awready_o, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .trigger_line_o);
